//--- pkg/data_space_defines.vh
// constants for the data-space byte/word access block
`ifndef DATA_SPACE_DEFINES_VH
`define DATA_SPACE_DEFINES_VH
`define NEAR_TOP      16'h1FFF
`define SFR_TOP       16'h07FF
`define NEAR_FIELD_W  13
`define REGION_SHIFT  5
`define REGION_COUNT  64
`define STEP_BYTE     16'h0001
`define STEP_WORD     16'h0002
`define SFR_MAP       64'h0000_00FF_FFFF_FFFF
`define MODE_INDIRECT 2'h0
`define MODE_NEAR     2'h1
`define MODE_FULL     2'h2
`define OP_MOVE       3'h0
`define OP_SIGN_EXT   3'h1
`define OP_ZERO_EXT   3'h2
`define OP_WORD_ONLY  3'h3
`define OP_OTHER      3'h4
`define ST_IDLE       2'h0
`define ST_READ       2'h1
`define ST_TRAP       2'h2
`define WREG_RESET    16'h0000
`endif

//--- hdl/sfr_region_decode.v
// decode of near data region and special function register space
`timescale 1ns/100ps
`include "data_space_defines.vh"
module sfr_region_decode (
  input  wire [15:0] addr_i,
  output wire        near_o,
  output wire        sfr_o,
  output wire        impl_o
);
  wire [5:0]  region;
  wire [63:0] map;
  assign map    = `SFR_MAP;
  assign near_o = (addr_i <= `NEAR_TOP);
  assign sfr_o  = (addr_i <= `SFR_TOP);
  assign region = addr_i[10:5];
  // a region is all-or-nothing: decode only to 32 byte granularity
  assign impl_o = sfr_o & map[region];
endmodule

//--- hdl/byte_lane_ram.v
// data memory built as two byte lanes with shared word decode
`timescale 1ns/100ps
module byte_lane_ram (
  input  wire        CLK_I,
  input  wire [8:0]  word_addr_i,
  input  wire        we_lo_i,
  input  wire        we_hi_i,
  input  wire [15:0] wdata_i,
  output wire [15:0] rdata_o
);
  reg [7:0] lo_mem [0:511];
  reg [7:0] hi_mem [0:511];
  always @(posedge CLK_I) begin
    if (we_lo_i) begin
      lo_mem[word_addr_i] <= wdata_i[7:0];
    end
    if (we_hi_i) begin
      hi_mem[word_addr_i] <= wdata_i[15:8];
    end
  end
  assign rdata_o = {hi_mem[word_addr_i], lo_mem[word_addr_i]};
endmodule

//--- hdl/data_space_access.v
// data-space access unit: address forming, lane steering, alignment trap
// How it works
// - post-increment steps 1 byte, 2 word
// - byte read selects byte by address lsb
// - two byte lanes, shared decode, separate strobes
// - odd word address raises address error
// - read completes, write suppressed, then trap
// - byte load keeps working register high byte
// - sign extend copies bit 7 upward
// - zero extend clears upper byte
// - near region reached by 13-bit field
// - far data indirect, or move full address
// - 0000h-07FFh decoded as register space
// - unimplemented register space reads zero
// - register space decoded in 32-byte regions
// - some operations accept word size only
`timescale 1ns/100ps
`include "data_space_defines.vh"
module data_space_access (
  input  wire        CLK_I,
  input  wire        RST_N_I,
  input  wire        START_I,
  input  wire [2:0]  OP_I,
  input  wire        BYTE_I,
  input  wire        WRITE_I,
  input  wire [1:0]  MODE_I,
  input  wire        POST_INC_I,
  input  wire [3:0]  SRC_REG_I,
  input  wire [3:0]  DST_REG_I,
  input  wire [15:0] DIRECT_ADDR_I,
  input  wire [15:0] WDATA_I,
  input  wire [15:0] SFR_RDATA_I,
  input  wire        ERR_CLR_I,
  output reg         DONE_O,
  output reg  [15:0] RDATA_O,
  output reg  [15:0] EFFECTIVE_ADDRESS_O,
  output reg         SFR_WE_LO_O,
  output reg         SFR_WE_HI_O,
  output reg  [15:0] SFR_WDATA_O,
  output reg         ADDR_ERR_O,
  output reg         TRAP_O,
  output reg         ILLEGAL_O
);
  reg  [15:0] wreg_q [0:15];
  reg  [1:0]  state_q;
  reg  [15:0] addr_q;
  reg         byte_q;
  reg  [3:0]  dst_q;
  reg         mis_q;
  reg  [15:0] effective_address;
  reg         legal;
  wire        near;
  wire        sfr;
  wire        impl;
  wire [15:0] ram_rdata;
  wire [15:0] source_work_reg;
  wire        misaligned;
  wire        ram_sel;
  wire        do_write;
  wire [15:0] lane_wdata;
  wire        we_lo;
  wire        we_hi;
  reg  [15:0] word_rd;
  reg  [7:0]  byte_rd;
  reg  [15:0] new_reg;
  wire        is_ext;
  wire        sign_extend_op;
  wire        zero_extend_op;
  wire [8:0]  ram_addr;
  wire        impl_q;
  assign source_work_reg = wreg_q[SRC_REG_I];
  assign sign_extend_op  = (OP_I == `OP_SIGN_EXT);
  assign zero_extend_op  = (OP_I == `OP_ZERO_EXT);
  assign is_ext          = sign_extend_op | zero_extend_op;

  // address forming per addressing mode
  always @* begin
    effective_address = source_work_reg;
    legal             = 1'b1;
    case (MODE_I)
      `MODE_INDIRECT: effective_address = source_work_reg;
      `MODE_NEAR: begin
        effective_address = {3'b000,
                             DIRECT_ADDR_I[`NEAR_FIELD_W-1:0]};
      end
      `MODE_FULL: begin
        effective_address = DIRECT_ADDR_I;
        // only moves carry the 16-bit direct field
        legal = (OP_I == `OP_MOVE);
      end
      default: legal = 1'b0;
    endcase
    if (OP_I == `OP_WORD_ONLY && BYTE_I) begin
      legal = 1'b0;
    end
  end

  sfr_region_decode u_dec (
    .addr_i (effective_address),
    .near_o (near),
    .sfr_o  (sfr),
    .impl_o (impl)
  );

  // read data is steered from the captured address, not the live inputs
  sfr_region_decode u_dec_q (
    .addr_i (addr_q),
    .near_o (),
    .sfr_o  (),
    .impl_o (impl_q)
  );
  assign ram_addr = (state_q == `ST_READ) ? addr_q[9:1]
                                          : effective_address[9:1];

  assign misaligned = !BYTE_I && effective_address[0];
  assign ram_sel    = !sfr;
  assign do_write   = START_I && WRITE_I && legal && !is_ext
                      && (state_q == `ST_IDLE);
  // a misaligned write still runs but never touches memory
  assign lane_wdata = BYTE_I ? {WDATA_I[7:0], WDATA_I[7:0]} : WDATA_I;
  assign we_lo = do_write && !misaligned
                 && (!BYTE_I || !effective_address[0]);
  assign we_hi = do_write && !misaligned
                 && (!BYTE_I || effective_address[0]);

  byte_lane_ram u_ram (
    .CLK_I       (CLK_I),
    .word_addr_i (ram_addr),
    .we_lo_i     (we_lo && ram_sel),
    .we_hi_i     (we_hi && ram_sel),
    .wdata_i     (lane_wdata),
    .rdata_o     (ram_rdata)
  );

  // read steering from the captured address
  always @* begin
    if (addr_q <= `SFR_TOP) begin
      word_rd = impl_q ? SFR_RDATA_I : 16'h0000;
    end else begin
      word_rd = ram_rdata;
    end
    byte_rd = addr_q[0] ? word_rd[15:8] : word_rd[7:0];
    new_reg = wreg_q[dst_q];
    if (byte_q) begin
      new_reg = {new_reg[15:8], byte_rd};
    end else begin
      new_reg = word_rd;
    end
  end

  integer i;
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (i = 0; i < 16; i = i + 1) begin
        wreg_q[i] <= `WREG_RESET;
      end
      state_q             <= `ST_IDLE;
      addr_q              <= 16'h0000;
      byte_q              <= 1'b0;
      dst_q               <= 4'h0;
      mis_q               <= 1'b0;
      DONE_O              <= 1'b0;
      RDATA_O             <= 16'h0000;
      EFFECTIVE_ADDRESS_O <= 16'h0000;
      SFR_WE_LO_O         <= 1'b0;
      SFR_WE_HI_O         <= 1'b0;
      SFR_WDATA_O         <= 16'h0000;
      ADDR_ERR_O          <= 1'b0;
      TRAP_O              <= 1'b0;
      ILLEGAL_O           <= 1'b0;
    end else begin
      DONE_O      <= 1'b0;
      TRAP_O      <= 1'b0;
      ILLEGAL_O   <= 1'b0;
      SFR_WE_LO_O <= we_lo && sfr;
      SFR_WE_HI_O <= we_hi && sfr;
      SFR_WDATA_O <= lane_wdata;
      if (ERR_CLR_I) begin
        ADDR_ERR_O <= 1'b0;
      end
      case (state_q)
        `ST_IDLE: begin
          if (START_I && !legal) begin
            ILLEGAL_O <= 1'b1;
            DONE_O    <= 1'b1;
          end else if (START_I && is_ext) begin
            if (sign_extend_op) begin
              wreg_q[DST_REG_I] <= {{8{source_work_reg[7]}},
                                    source_work_reg[7:0]};
            end else begin
              wreg_q[DST_REG_I] <= {8'h00,
                                    source_work_reg[7:0]};
            end
            DONE_O <= 1'b1;
          end else if (START_I) begin
            EFFECTIVE_ADDRESS_O <= effective_address;
            addr_q  <= effective_address;
            byte_q  <= BYTE_I;
            dst_q   <= DST_REG_I;
            mis_q   <= misaligned;
            if (MODE_I == `MODE_INDIRECT && POST_INC_I) begin
              wreg_q[SRC_REG_I] <= source_work_reg +
                (BYTE_I ? `STEP_BYTE : `STEP_WORD);
            end
            if (WRITE_I) begin
              DONE_O <= 1'b1;
              if (misaligned) begin
                state_q <= `ST_TRAP;
              end
            end else begin
              state_q <= `ST_READ;
            end
          end
        end
        `ST_READ: begin
          // the read still finishes even when misaligned
          wreg_q[dst_q] <= new_reg;
          RDATA_O <= new_reg;
          DONE_O  <= 1'b1;
          state_q <= mis_q ? `ST_TRAP : `ST_IDLE;
        end
        `ST_TRAP: begin
          // set wins over a same-cycle clear
          ADDR_ERR_O <= 1'b1;
          TRAP_O     <= 1'b1;
          state_q    <= `ST_IDLE;
        end
        default: state_q <= `ST_IDLE;
      endcase
    end
  end
endmodule

//--- dv/dsa_sva.sv
// assertions on the data_space_access ports
`timescale 1ns/100ps
module dsa_sva (
  input wire        CLK_I,
  input wire        RST_N_I,
  input wire        ERR_CLR_I,
  input wire        DONE_O,
  input wire [15:0] EFFECTIVE_ADDRESS_O,
  input wire        SFR_WE_LO_O,
  input wire        SFR_WE_HI_O,
  input wire        ADDR_ERR_O,
  input wire        TRAP_O,
  input wire        ILLEGAL_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire w = SFR_WE_LO_O | SFR_WE_HI_O;
  wire b = SFR_WE_LO_O ^ SFR_WE_HI_O;
  property p_after; TRAP_O |-> $past(DONE_O); endproperty
  a_after: assert property (p_after) else $error("trap early");
  property p_nowr; TRAP_O |-> !$past(w); endproperty
  a_nowr: assert property (p_nowr) else $error("write kept");
  property p_flag; TRAP_O |-> ADDR_ERR_O; endproperty
  a_flag: assert property (p_flag) else $error("no flag");
  property p_keep; ADDR_ERR_O && !ERR_CLR_I |=> ADDR_ERR_O; endproperty
  a_keep: assert property (p_keep) else $error("flag lost");
  property p_set; $rose(ADDR_ERR_O) |-> TRAP_O; endproperty
  a_set: assert property (p_set) else $error("flag alone");
  property p_rng; w |-> EFFECTIVE_ADDRESS_O <= 16'h07FF; endproperty
  a_rng: assert property (p_rng) else $error("strobe range");
  property p_lane; b |-> SFR_WE_HI_O == EFFECTIVE_ADDRESS_O[0]; endproperty
  a_lane: assert property (p_lane) else $error("wrong lane");
  property p_even; SFR_WE_LO_O && SFR_WE_HI_O |-> !EFFECTIVE_ADDRESS_O[0];
  endproperty
  a_even: assert property (p_even) else $error("odd word");
  property p_ill; ILLEGAL_O |-> !w ##1 !TRAP_O; endproperty
  a_ill: assert property (p_ill) else $error("illegal acts");
  c_trap: cover property (TRAP_O);
  c_ill: cover property (ILLEGAL_O);
  c_byte: cover property (b);
endmodule
bind data_space_access dsa_sva u_sva (.*);

//--- dv/sfr_model.sv
// register-space responder beside data_space_access
`timescale 1ns/100ps
module sfr_model (
  input  wire        clk_i,
  input  wire [15:0] addr_i,
  input  wire        we_lo_i,
  input  wire        we_hi_i,
  input  wire [15:0] wdata_i,
  output wire [15:0] rdata_o
);
  reg [15:0] m [0:1023];
  integer i;
  initial for (i = 0; i < 1024; i = i + 1) m[i] = ~i[15:0];
  // answers everywhere, so empty regions must be masked upstream
  assign rdata_o = m[addr_i[10:1]];
  always @(posedge clk_i) begin
    if (we_lo_i) m[addr_i[10:1]][7:0] <= wdata_i[7:0];
    if (we_hi_i) m[addr_i[10:1]][15:8] <= wdata_i[15:8];
  end
endmodule

//--- dv/testbench.sv
// self-checking bench for data_space_access
`timescale 1ns/100ps
module testbench;
  reg CLK_I = 0, RST_N_I = 0, START_I = 0, BYTE_I = 0, WRITE_I = 0;
  reg POST_INC_I = 0, ERR_CLR_I = 0;
  reg [2:0] OP_I = 0;
  reg [1:0] MODE_I = 0;
  reg [3:0] SRC_REG_I = 0, DST_REG_I = 0;
  reg [15:0] DIRECT_ADDR_I = 0, WDATA_I = 0;
  wire [15:0] SFR_RDATA_I, RDATA_O, EFFECTIVE_ADDRESS_O, SFR_WDATA_O;
  wire DONE_O, SFR_WE_LO_O, SFR_WE_HI_O, ADDR_ERR_O, TRAP_O, ILLEGAL_O;
  integer bad_count = 0, check_count = 0;
  reg [15:0] rd, ea;
  reg tr, il;
  always #50 CLK_I = ~CLK_I;
  data_space_access DUT (.*);
  sfr_model u_sfr (.clk_i(CLK_I), .addr_i(EFFECTIVE_ADDRESS_O),
    .we_lo_i(SFR_WE_LO_O), .we_hi_i(SFR_WE_HI_O),
    .wdata_i(SFR_WDATA_O), .rdata_o(SFR_RDATA_I));
  task close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk(input string n, input [15:0] e, g);
    check_count = check_count + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task op(input [2:0] o, input b, w, input [1:0] md, input [3:0] s, d,
          input [15:0] a, wd, input pi);
    integer k;
    k = 0;
    @(posedge CLK_I);
    {OP_I, BYTE_I, WRITE_I, MODE_I, SRC_REG_I, DST_REG_I, DIRECT_ADDR_I,
     WDATA_I, POST_INC_I, START_I} <= {o, b, w, md, s, d, a, wd, pi, 1'b1};
    @(posedge CLK_I);
    START_I <= 1'b0;
    #1;
    while (DONE_O !== 1'b1 && k < 20) begin
      @(posedge CLK_I);
      #1;
      k = k + 1;
    end
    if (DONE_O !== 1'b1) begin
      bad_count = bad_count + 1;
      close_out;
    end
    rd = RDATA_O;
    ea = EFFECTIVE_ADDRESS_O;
    il = ILLEGAL_O;
    @(posedge CLK_I);
    #1;
    tr = TRAP_O;
  endtask
  task wr(input b, input [15:0] a, wd);
    op(0, b, 1, 1, 0, 0, a, wd, 0);
  endtask
  task rdm(input b, input [3:0] d, input [15:0] a);
    op(0, b, 0, 1, 0, d, a, 0, 0);
  endtask
  task t_lane;
    wr(0, 16'hE800, 16'h1234);
    chk("near", 16'h0800, ea);
    wr(0, 16'h0802, 16'h00C7);
    wr(1, 16'h0801, 16'h00AB);
    rdm(0, 1, 16'h0800);
    chk("word", 16'hAB34, rd);
    rdm(0, 2, 16'h0800);
    rdm(1, 2, 16'h0802);
    chk("byte even", 16'hABC7, rd);
    rdm(1, 3, 16'h0801);
    chk("byte odd", 16'h00AB, rd);
    $display("lane test done");
  endtask
  task t_ext;
    op(1, 1, 0, 0, 2, 4, 0, 0, 0);
    op(2, 1, 0, 0, 2, 5, 0, 0, 0);
    op(0, 1, 0, 0, 4, 6, 0, 0, 1);
    chk("sext", 16'hFFC7, ea);
    op(0, 1, 0, 0, 4, 6, 0, 0, 0);
    chk("inc byte", 16'hFFC8, ea);
    op(0, 1, 0, 0, 5, 6, 0, 0, 0);
    chk("zext", 16'h00C7, ea);
    op(0, 0, 0, 0, 4, 6, 0, 0, 1);
    op(0, 0, 0, 0, 4, 6, 0, 0, 0);
    chk("inc word", 16'hFFCA, ea);
    $display("extend test done");
  endtask
  task t_trap;
    wr(0, 16'h0804, 16'h1111);
    wr(0, 16'h0805, 16'hFFFF);
    chk("trap w", 16'h0003, {14'h0, tr, ADDR_ERR_O});
    rdm(0, 7, 16'h0804);
    chk("kept", 16'h1111, rd);
    @(posedge CLK_I);
    ERR_CLR_I <= 1'b1;
    @(posedge CLK_I);
    ERR_CLR_I <= 1'b0;
    #1;
    chk("clear", 16'h0000, {15'h0, ADDR_ERR_O});
    rdm(0, 7, 16'h0803);
    chk("trap r", 16'h0001, {15'h0, tr});
    $display("trap test done");
  endtask
  task t_sfr;
    wr(0, 16'h04E0, 16'h1357);
    wr(1, 16'h04E1, 16'h005A);
    rdm(0, 8, 16'h04E0);
    chk("sfr", 16'h5A57, rd);
    rdm(0, 8, 16'h0500);
    chk("empty", 16'h0000, rd);
    op(1, 1, 0, 2, 2, 8, 16'h0800, 0, 0);
    chk("full op", 16'h0001, {15'h0, il});
    op(3, 1, 0, 1, 0, 8, 16'h0800, 0, 0);
    chk("word only", 16'h0001, {15'h0, il});
    op(0, 0, 0, 2, 0, 8, 16'hE800, 0, 0);
    chk("move", 16'hAB34, rd);
    $display("sfr test done");
  endtask
  initial begin
    repeat (6) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    t_lane;
    t_ext;
    t_trap;
    t_sfr;
    close_out;
  end
endmodule
